// ---- hdl/gpl_axil_slave.sv ----
// AXI4-Lite slave front end producing single-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
module gpl_axil_slave
	import gpl_pkg::*;
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_b_in,
	// Write channels
	input wire logic [7:0] awaddr_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	// Read channels
	input wire logic [7:0] araddr_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in,
	// Register side
	gpl_reg_if.bus rif
);
	logic aw_full_r;
	logic w_full_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic commit;
	logic ar_hs;

	// Address and data may come in either order; commit once both held
	assign commit = aw_full_r && w_full_r && !bvalid_out;
	assign ar_hs = arvalid_in && arready_out;
	assign rif.wr_en = commit;
	assign rif.wr_addr = awaddr_r;
	assign rif.wr_data = wdata_r;
	assign rif.wr_strb = wstrb_r;
	assign rif.rd_en = ar_hs;
	assign rif.rd_addr = araddr_in;

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
		begin
			aw_full_r <= 1'b0;
			awready_out <= 1'b0;
			awaddr_r <= 8'h00;
		end
		else if (awvalid_in && awready_out)
		begin
			aw_full_r <= 1'b1;
			awready_out <= 1'b0;
			awaddr_r <= awaddr_in;
		end
		else if (commit)
			aw_full_r <= 1'b0;
		else if (!aw_full_r && !bvalid_out)
			awready_out <= 1'b1;
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
		begin
			w_full_r <= 1'b0;
			wready_out <= 1'b0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end
		else if (wvalid_in && wready_out)
		begin
			w_full_r <= 1'b1;
			wready_out <= 1'b0;
			wdata_r <= wdata_in;
			wstrb_r <= wstrb_in;
		end
		else if (commit)
			w_full_r <= 1'b0;
		else if (!w_full_r && !bvalid_out)
			wready_out <= 1'b1;
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
		begin
			bvalid_out <= 1'b0;
			bresp_out <= RESP_OKAY;
		end
		else if (commit)
		begin
			bvalid_out <= 1'b1;
			bresp_out <= rif.wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		else if (bready_in)
			bvalid_out <= 1'b0;
	end

	// Read data is sampled at the address handshake, one read in flight
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
		begin
			arready_out <= 1'b0;
			rvalid_out <= 1'b0;
			rdata_out <= 32'h0000_0000;
			rresp_out <= RESP_OKAY;
		end
		else if (ar_hs)
		begin
			arready_out <= 1'b0;
			rvalid_out <= 1'b1;
			rdata_out <= rif.rd_data;
			rresp_out <= rif.rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		else if (rvalid_out && rready_in)
			rvalid_out <= 1'b0;
		else if (!rvalid_out)
			arready_out <= 1'b1;
	end
endmodule : gpl_axil_slave
`default_nettype wire

// ---- hdl/gpl_gpio_top.sv ----
// Output latch, set/clear port, configuration lock and alternate selector
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpl_gpio_top
	import gpl_pkg::*;
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_b_in,
	// AXI4-Lite write
	input wire logic [7:0] awaddr_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	// AXI4-Lite read
	input wire logic [7:0] araddr_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in,
	// Pin side
	output logic [7:0] out_latch_out,
	output logic [15:0] pin_mode_field_out,
	output logic [31:0] pin_alt_function_code_out,
	output logic [7:0] alt_route_en_out,
	output logic [7:0] pin_lock_bit_out,
	output logic lock_key_bit_out
);
	gpl_reg_if rif ();

	logic [15:0] mode_r;
	logic [31:0] alt_r;
	logic [7:0] lck_r;
	logic lock_key_bit;
	logic [31:0] wmask;
	logic [31:0] frz_mode;
	logic [31:0] frz_alt;
	logic [7:0] set_bits;
	logic [7:0] clr_bits;
	logic wr_mode;
	logic wr_latch;
	logic wr_bsc;
	logic wr_lock;
	logic wr_alt;

	// ****************
	// Bus front end and lock sequence
	// ****************
	gpl_axil_slave u_bus (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.awaddr_in(awaddr_in),
		.awvalid_in(awvalid_in),
		.awready_out(awready_out),
		.wdata_in(wdata_in),
		.wstrb_in(wstrb_in),
		.wvalid_in(wvalid_in),
		.wready_out(wready_out),
		.bresp_out(bresp_out),
		.bvalid_out(bvalid_out),
		.bready_in(bready_in),
		.araddr_in(araddr_in),
		.arvalid_in(arvalid_in),
		.arready_out(arready_out),
		.rdata_out(rdata_out),
		.rresp_out(rresp_out),
		.rvalid_out(rvalid_out),
		.rready_in(rready_in),
		.rif(rif.bus)
	);

	gpl_lock_seq u_lock (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.wr_in(wr_lock),
		.full_word_in(rif.wr_strb == STRB_FULL),
		.key_bit_in(rif.wr_data[LOCK_KEY_POS]),
		.pins_in(rif.wr_data[7:0]),
		.rd_in(rif.rd_en && rif.rd_addr == OFS_CONFIG_LOCK),
		.key_out(lock_key_bit)
	);

	// ****************
	// Write decode
	// ****************
	assign wr_mode = rif.wr_en && rif.wr_addr == OFS_MODE;
	assign wr_latch = rif.wr_en && rif.wr_addr == OFS_OUT_LATCH;
	assign wr_bsc = rif.wr_en && rif.wr_addr == OFS_BIT_SET_CLEAR;
	assign wr_lock = rif.wr_en && rif.wr_addr == OFS_CONFIG_LOCK;
	assign wr_alt = rif.wr_en && rif.wr_addr == OFS_ALT_LOW;
	assign rif.wr_err = !gpl_mapped(rif.wr_addr);
	assign wmask = gpl_byte_mask(rif.wr_strb);
	// Locked fields only freeze once the key is live
	assign frz_mode = lock_key_bit ? gpl_pin_mask(lck_r, MODE_W) : '0;
	assign frz_alt = lock_key_bit ? gpl_pin_mask(lck_r, AF_W) : '0;
	assign set_bits = rif.wr_data[BSC_SET_LSB +: 8] & wmask[7:0];
	assign clr_bits = rif.wr_data[BSC_CLR_LSB +: 8] & wmask[23:16];

	// ****************
	// Registers
	// ****************
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			out_latch_out <= RST_OUT_LATCH;
		else if (wr_latch)
			out_latch_out <= (out_latch_out & ~wmask[7:0]) |
				(rif.wr_data[7:0] & wmask[7:0]);
		else if (wr_bsc)
			out_latch_out <= (out_latch_out & ~clr_bits) | set_bits;
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			mode_r <= RST_MODE;
		else if (wr_mode)
			mode_r <= (mode_r & (frz_mode[15:0] | ~wmask[15:0])) |
				(rif.wr_data[15:0] & wmask[15:0] & ~frz_mode[15:0]);
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			alt_r <= RST_ALT_LOW;
		else if (wr_alt)
			alt_r <= (alt_r & (frz_alt | ~wmask)) |
				(rif.wr_data & wmask & ~frz_alt);
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			lck_r <= RST_PIN_LOCK;
		else if (wr_lock && !lock_key_bit && rif.wr_strb[0])
			lck_r <= rif.wr_data[7:0];
	end

	// Route enable lags the mode field by one cycle to stay a flop output
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			alt_route_en_out <= 8'h00;
		else
			for (int i = 0; i < PINS; i++)
				alt_route_en_out[i] <=
					mode_r[i * MODE_W +: MODE_W] == MODE_ALT;
	end

	assign pin_mode_field_out = mode_r;
	assign pin_alt_function_code_out = alt_r;
	assign pin_lock_bit_out = lck_r;
	assign lock_key_bit_out = lock_key_bit;

	// ****************
	// Read mux
	// ****************
	always_comb
	begin
		rif.rd_err = !gpl_mapped(rif.rd_addr);
		case (rif.rd_addr)
			OFS_MODE: rif.rd_data = {16'h0000, mode_r};
			OFS_OUT_LATCH: rif.rd_data = {24'h00_0000, out_latch_out};
			OFS_BIT_SET_CLEAR: rif.rd_data = 32'h0000_0000;
			OFS_CONFIG_LOCK:
				rif.rd_data = {15'h0000, lock_key_bit, 8'h00, lck_r};
			OFS_ALT_LOW: rif.rd_data = alt_r;
			default: rif.rd_data = 32'h0000_0000;
		endcase
	end

	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);

	property p_latch_wr;
		(wr_latch && rif.wr_strb[0]) |=> out_latch_out == $past(rif.wr_data[7:0]);
	endproperty
	a_latch_wr: assert property (p_latch_wr)
		else $error("output latch did not take written value");

	property p_set_wins;
		wr_bsc |=> (out_latch_out & $past(set_bits)) == $past(set_bits);
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("set request left a pin low");

	property p_clear;
		wr_bsc |=> (out_latch_out & $past(clr_bits & ~set_bits)) == 8'h00;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear request left a pin high");

	property p_bsc_reads_zero;
		(arvalid_in && arready_out && araddr_in == OFS_BIT_SET_CLEAR) |=>
			rvalid_out && rdata_out == 32'h0000_0000;
	endproperty
	a_bsc_reads_zero: assert property (p_bsc_reads_zero)
		else $error("set/clear register read non-zero");

	property p_key_sticks;
		lock_key_bit |=> lock_key_bit;
	endproperty
	a_key_sticks: assert property (p_key_sticks)
		else $error("lock key dropped without reset");

	property p_pins_frozen;
		lock_key_bit |=> $stable(lck_r);
	endproperty
	a_pins_frozen: assert property (p_pins_frozen)
		else $error("pin lock bits changed with key active");

	property p_alt_frozen;
		lock_key_bit |=> ((alt_r ^ $past(alt_r)) & $past(frz_alt)) == 0;
	endproperty
	a_alt_frozen: assert property (p_alt_frozen)
		else $error("locked alternate field changed");

	property p_mode_frozen;
		lock_key_bit |=>
			((mode_r ^ $past(mode_r)) & $past(frz_mode[15:0])) == 16'h0000;
	endproperty
	a_mode_frozen: assert property (p_mode_frozen)
		else $error("locked mode field changed");

	property p_route;
		##1 alt_route_en_out[0] == ($past(mode_r[1:0]) == MODE_ALT);
	endproperty
	a_route: assert property (p_route)
		else $error("pin 0 routing does not follow its mode");

	property p_lock_take;
		(wr_lock && !lock_key_bit && rif.wr_strb[0]) |=>
			lck_r == $past(rif.wr_data[7:0]);
	endproperty
	a_lock_take: assert property (p_lock_take)
		else $error("pin lock bits did not take an open write");

	property p_alt_take;
		(wr_alt && !lock_key_bit && rif.wr_strb == STRB_FULL) |=>
			alt_r == $past(rif.wr_data);
	endproperty
	a_alt_take: assert property (p_alt_take)
		else $error("selector did not take an unlocked write");

	property p_mode_take;
		(wr_mode && !lock_key_bit && rif.wr_strb[1:0] == 2'h3) |=>
			mode_r == $past(rif.wr_data[15:0]);
	endproperty
	a_mode_take: assert property (p_mode_take)
		else $error("mode field did not take an unlocked write");

	property p_latch_read;
		(rif.rd_en && rif.rd_addr == OFS_OUT_LATCH) |=>
			rdata_out == {24'h00_0000, $past(out_latch_out)};
	endproperty
	a_latch_read: assert property (p_latch_read)
		else $error("output latch read back wrong");

	property p_key_read;
		(rif.rd_en && rif.rd_addr == OFS_CONFIG_LOCK) |=>
			rdata_out[LOCK_KEY_POS] == $past(lock_key_bit);
	endproperty
	a_key_read: assert property (p_key_read)
		else $error("lock key bit read back wrong");

	property p_lock_reserved;
		(rif.rd_en && rif.rd_addr == OFS_CONFIG_LOCK) |=>
			rdata_out[31:17] == 15'h0000 && rdata_out[15:8] == 8'h00;
	endproperty
	a_lock_reserved: assert property (p_lock_reserved)
		else $error("reserved lock register bits read non-zero");

	property p_unmapped_rd;
		(rif.rd_en && rif.rd_err) |=>
			rdata_out == 32'h0000_0000 && rresp_out == RESP_SLVERR;
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd)
		else $error("unmapped read returned data or no error");

	property p_unmapped_wr;
		(rif.wr_en && rif.wr_err) |=>
			$stable(out_latch_out) && $stable(mode_r) && $stable(alt_r) &&
			$stable(lck_r) && bresp_out == RESP_SLVERR;
	endproperty
	a_unmapped_wr: assert property (p_unmapped_wr)
		else $error("unmapped write changed state or returned okay");

	c_set_and_clear: cover property (wr_bsc && (set_bits & clr_bits) != 0);
	c_unmapped_read: cover property (rvalid_out && rresp_out == RESP_SLVERR);
	c_locked_alt_write: cover property (wr_alt && frz_alt != 0);
endmodule : gpl_gpio_top
`default_nettype wire

// ---- hdl/gpl_lock_seq.sv ----
// Keyed write sequence that arms the configuration lock
`timescale 1ns/1ps
`default_nettype none
module gpl_lock_seq
	import gpl_pkg::*;
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_b_in,
	// Accesses to the lock register
	input wire logic wr_in,
	input wire logic full_word_in,
	input wire logic key_bit_in,
	input wire logic [7:0] pins_in,
	input wire logic rd_in,
	// Key state
	output logic key_out
);
	gpl_lock_state_type state_r;
	gpl_lock_state_type state_nxt;
	logic [7:0] held_r;
	logic ok;

	// Every step must be a full word with the pin bits unchanged
	assign ok = full_word_in && pins_in == held_r;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			LKS_IDLE:
				if (wr_in && full_word_in && key_bit_in)
					state_nxt = LKS_ONE;
			LKS_ONE:
				if (wr_in)
					state_nxt = (ok && !key_bit_in) ? LKS_ZERO : LKS_IDLE;
			LKS_ZERO:
				if (wr_in)
					state_nxt = (ok && key_bit_in) ? LKS_ARMED : LKS_IDLE;
			LKS_ARMED:
				if (wr_in)
					state_nxt = LKS_IDLE;
				else if (rd_in)
					state_nxt = LKS_IDLE;
			default:
				state_nxt = LKS_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			state_r <= LKS_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			held_r <= RST_PIN_LOCK;
		else if (state_r == LKS_IDLE && wr_in)
			held_r <= pins_in;
	end

	// Key is raised only by the read that ends the sequence
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			key_out <= 1'b0;
		else if (state_r == LKS_ARMED && rd_in && !wr_in)
			key_out <= 1'b1;
	end

	property p_key_cause;
		@(posedge mclk_in) disable iff (!rst_b_in)
		$rose(key_out) |-> $past(state_r == LKS_ARMED && rd_in);
	endproperty
	a_key_cause: assert property (p_key_cause)
		else $error("lock key rose without a completed sequence");

	property p_bad_step;
		@(posedge mclk_in) disable iff (!rst_b_in)
		(state_r != LKS_IDLE && wr_in && !ok) |=> state_r == LKS_IDLE;
	endproperty
	a_bad_step: assert property (p_bad_step)
		else $error("faulty lock step did not abort the sequence");

	c_key_armed: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
		$rose(key_out));
endmodule : gpl_lock_seq
`default_nettype wire

// ---- hdl/gpl_pkg.sv ----
// Constants, types and helpers shared by the port register block
`default_nettype none
package gpl_pkg;
	// ****************
	// Widths
	// ****************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PINS = 8;
	localparam int MODE_W = 2;
	localparam int AF_W = 4;

	// ****************
	// Register offsets
	// ****************
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_OUT_LATCH = 8'h14;
	localparam logic [7:0] OFS_BIT_SET_CLEAR = 8'h18;
	localparam logic [7:0] OFS_CONFIG_LOCK = 8'h1C;
	localparam logic [7:0] OFS_ALT_LOW = 8'h20;

	// ****************
	// Reset values and fields
	// ****************
	localparam logic [15:0] RST_MODE = 16'hFFFF;
	localparam logic [7:0] RST_OUT_LATCH = 8'h00;
	localparam logic [7:0] RST_PIN_LOCK = 8'h00;
	localparam logic [31:0] RST_ALT_LOW = 32'h0000_0000;
	localparam int BSC_SET_LSB = 0;
	localparam int BSC_CLR_LSB = 16;
	localparam int LOCK_KEY_POS = 16;
	localparam logic [1:0] MODE_ALT = 2'h2;
	localparam logic [3:0] STRB_FULL = 4'hF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0]
	{
		LKS_IDLE = 4'h1,
		LKS_ONE = 4'h2,
		LKS_ZERO = 4'h4,
		LKS_ARMED = 4'h8
	} gpl_lock_state_type;

	// ****************
	// Helpers
	// ****************
	function automatic logic [31:0] gpl_byte_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 32; i++)
			m[i] = strb[i / 8];
		return m;
	endfunction : gpl_byte_mask

	// Widens one bit per pin into a mask over that pin's field
	function automatic logic [31:0] gpl_pin_mask(input logic [7:0] pin,
		input int w);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 8; i++)
			for (int j = 0; j < w; j++)
				m[i * w + j] = pin[i];
		return m;
	endfunction : gpl_pin_mask

	function automatic logic gpl_mapped(input logic [7:0] a);
		return a == OFS_MODE || a == OFS_OUT_LATCH ||
			a == OFS_BIT_SET_CLEAR || a == OFS_CONFIG_LOCK ||
			a == OFS_ALT_LOW;
	endfunction : gpl_mapped
endpackage : gpl_pkg
`default_nettype wire

// ---- hdl/gpl_reg_if.sv ----
// Internal register access path between bus slave and register file
`timescale 1ns/1ps
`default_nettype none
interface gpl_reg_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_en;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;
	modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_err, rd_data, rd_err);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_err, rd_data, rd_err);
endinterface : gpl_reg_if
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the port register block over its register bus
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import gpl_pkg::*;
;
	// ****************
	// Bench signals
	// ****************
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b1;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, key;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, alt_code;
	logic [7:0] latch, route, lock_bits;
	logic [15:0] mode;
	logic [1:0] resp;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	gpl_gpio_top gpl_gpio_top_i (
		.mclk_in(mclk), .rst_b_in(rst_b),
		.awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
		.wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
		.wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
		.bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
		.arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
		.rvalid_out(rvalid), .rready_in(rready),
		.out_latch_out(latch), .pin_mode_field_out(mode),
		.pin_alt_function_code_out(alt_code), .alt_route_en_out(route),
		.pin_lock_bit_out(lock_bits), .lock_key_bit_out(key)
	);

	always #50 mclk = ~mclk;

	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			print_verdict();
		end
	end

	// ****************
	// Tasks
	// ****************
	task automatic print_verdict();
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Bready stays high, so the answer is taken at the edge it shows
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		bit done;
		done = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!done)
		begin
			@(posedge mclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
			begin
				r = bresp;
				done = 1'b1;
			end
		end
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit done;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		while (!done)
		begin
			@(posedge mclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
			begin
				d = rdata;
				r = rresp;
				done = 1'b1;
			end
		end
	endtask : axi_read

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		axi_write(a, d, s, resp);
		check({30'h0, resp}, {30'h0, RESP_OKAY});
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		axi_read(a, d, resp);
		check({30'h0, resp}, {30'h0, RESP_OKAY});
		check(d, exp);
	endtask : rd_chk

	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
	endtask : do_reset

	// ****************
	// Main sequence
	// ****************
	initial
	begin
		logic [31:0] d;
		do_reset();
		// Reset values
		rd_chk(OFS_OUT_LATCH, 32'h0000_0000);
		rd_chk(OFS_CONFIG_LOCK, 32'h0000_0000);
		rd_chk(OFS_ALT_LOW, 32'h0000_0000);
		rd_chk(OFS_MODE, 32'h0000_FFFF);
		// Latch write with reserved bits set
		wr(OFS_OUT_LATCH, 32'hFFFF_FFA5, STRB_FULL);
		rd_chk(OFS_OUT_LATCH, 32'h0000_00A5);
		check({24'h0, latch}, 32'h0000_00A5);
		// Set low nibble, clear high nibble
		wr(OFS_BIT_SET_CLEAR, 32'h00F0_000F, STRB_FULL);
		check({24'h0, latch}, 32'h0000_000F);
		// Pin 4 set and cleared together, pin 0 cleared
		wr(OFS_BIT_SET_CLEAR, 32'h0011_0010, STRB_FULL);
		check({24'h0, latch}, 32'h0000_001E);
		// Only the clear byte enabled: set field ignored
		wr(OFS_BIT_SET_CLEAR, 32'h0002_0001, 4'h4);
		check({24'h0, latch}, 32'h0000_001C);
		rd_chk(OFS_BIT_SET_CLEAR, 32'h0000_0000);
		// Function codes 0 to 7, one per pin
		wr(OFS_ALT_LOW, 32'h7654_3210, STRB_FULL);
		rd_chk(OFS_ALT_LOW, 32'h7654_3210);
		check(alt_code, 32'h7654_3210);
		// Pins 0 and 7 in alternate mode
		wr(OFS_MODE, 32'h0000_8002, STRB_FULL);
		repeat (2) @(posedge mclk);
		check({24'h0, route}, 32'h0000_0081);
		// Unmapped address
		axi_write(8'h40, 32'hFFFF_FFFF, STRB_FULL, resp);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		axi_read(8'h40, d, resp);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		check(d, 32'h0000_0000);
		// Pin bits changed in mid-sequence: key must stay off
		wr(OFS_CONFIG_LOCK, 32'h0001_0003, STRB_FULL);
		wr(OFS_CONFIG_LOCK, 32'h0000_0003, STRB_FULL);
		wr(OFS_CONFIG_LOCK, 32'h0001_0007, STRB_FULL);
		rd_chk(OFS_CONFIG_LOCK, 32'h0000_0007);
		rd_chk(OFS_CONFIG_LOCK, 32'h0000_0007);
		// Proper keyed sequence locking pins 0 and 1
		wr(OFS_CONFIG_LOCK, 32'h0001_0003, STRB_FULL);
		wr(OFS_CONFIG_LOCK, 32'h0000_0003, STRB_FULL);
		wr(OFS_CONFIG_LOCK, 32'h0001_0003, STRB_FULL);
		rd_chk(OFS_CONFIG_LOCK, 32'h0000_0003);
		rd_chk(OFS_CONFIG_LOCK, 32'h0001_0003);
		check({31'h0, key}, 32'h0000_0001);
		// Lock bits refuse writes once the key is on
		wr(OFS_CONFIG_LOCK, 32'h0000_00FF, STRB_FULL);
		rd_chk(OFS_CONFIG_LOCK, 32'h0001_0003);
		check({24'h0, lock_bits}, 32'h0000_0003);
		// Locked pins keep mode and function fields
		wr(OFS_MODE, 32'hFFFF_FFFF, STRB_FULL);
		rd_chk(OFS_MODE, 32'h0000_FFF2);
		check({16'h0, mode}, 32'h0000_FFF2);
		wr(OFS_ALT_LOW, 32'hFFFF_FFFF, STRB_FULL);
		rd_chk(OFS_ALT_LOW, 32'hFFFF_FF10);
		repeat (2) @(posedge mclk);
		check({24'h0, route}, 32'h0000_0001);
		// Latch is never frozen
		wr(OFS_OUT_LATCH, 32'h0000_0055, STRB_FULL);
		rd_chk(OFS_OUT_LATCH, 32'h0000_0055);
		// Reset in mid-run releases the key
		do_reset();
		rd_chk(OFS_CONFIG_LOCK, 32'h0000_0000);
		check({31'h0, key}, 32'h0000_0000);
		rd_chk(OFS_MODE, 32'h0000_FFFF);
		// Partial strobe in mid-sequence: key must stay off
		wr(OFS_CONFIG_LOCK, 32'h0001_0003, STRB_FULL);
		wr(OFS_CONFIG_LOCK, 32'h0000_0003, 4'h1);
		wr(OFS_CONFIG_LOCK, 32'h0001_0003, STRB_FULL);
		rd_chk(OFS_CONFIG_LOCK, 32'h0000_0003);
		rd_chk(OFS_CONFIG_LOCK, 32'h0000_0003);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
